// File: pkg/fpd_map.svh
// Constants for the floating-point instruction format decoder.
// Assumes a 32-bit instruction word supplied aligned by the fetch stage.
//
// What this block does
// - Decode five-bit and three-bit format codes.
// - Conversions take result format from function.
// - Unimplemented format raises reserved-instruction exception only for function codes that decode to a class.
// - Arith, move, compare: single, double, paired only.
// - Divide, root, estimates: single or double only.
// - Convert-to-double from single, word, long.
// - Convert-to-single from double, word, long.
// - Upper/lower extraction takes paired single only.
// - Convert to long/word from single/double only.
// - Directed-rounding conversions: single/double sources only.
// - Conditional moves at 17-19: single, double, paired.
// - Pair merges 44-47 take paired single only.
// - Four-register ops 4-7: single, double, paired.
// - Each instruction is one aligned 32-bit word.
// - Immediate form: opcode, base, register, offset fields.
// - Register form field positions fixed.
// - Destination register field depends on instruction.
// - Only opcode, format and function fields identify instruction.
// - Extended function splits into select and format.
`ifndef FPD_MAP_SVH
`define FPD_MAP_SVH

// ----------------------------------------
// Major opcodes (arbitrary defaults, placement fixed by core)
// ----------------------------------------
`define FPD_OPC_FPU 6'h11
`define FPD_OPC_FPUX 6'h13
`define FPD_OPC_LDW 6'h31
`define FPD_OPC_LDD 6'h35
`define FPD_OPC_STW 6'h39
`define FPD_OPC_STD 6'h3d

// ----------------------------------------
// Five-bit format codes
// ----------------------------------------
`define FPD_FMT_S 5'h10
`define FPD_FMT_D 5'h11
`define FPD_FMT_W 5'h14
`define FPD_FMT_L 5'h15
`define FPD_FMT_PS 5'h16
`define FPD_FMT_BC 5'h08

// ----------------------------------------
// Three-bit format codes
// ----------------------------------------
`define FPD_F3_S 3'h0
`define FPD_F3_D 3'h1
`define FPD_F3_W 3'h4
`define FPD_F3_L 3'h5
`define FPD_F3_PS 3'h6

// ----------------------------------------
// Function values
// ----------------------------------------
`define FPD_FN_ADD 6'h00
`define FPD_FN_SUB 6'h01
`define FPD_FN_MUL 6'h02
`define FPD_FN_DIV 6'h03
`define FPD_FN_SQUARE_ROOT 6'h04
`define FPD_FN_ABS 6'h05
`define FPD_FN_MOV 6'h06
`define FPD_FN_NEG 6'h07
`define FPD_FN_RND_LO 6'h08
`define FPD_FN_RND_HI 6'h0f
`define FPD_FN_MOVCC 6'h11
`define FPD_FN_MOVE_IF_GPR_ZERO 6'h12
`define FPD_FN_MOVE_IF_GPR_NONZERO 6'h13
`define FPD_FN_INV 6'h15
`define FPD_FN_INVRT 6'h16
`define FPD_FN_CVS 6'h20
`define FPD_FN_CVD 6'h21
`define FPD_FN_CVW 6'h24
`define FPD_FN_CVL 6'h25
`define FPD_FN_CVPL 6'h28
`define FPD_FN_PAIR_LO 6'h2c
`define FPD_FN_PAIR_HI 6'h2f
`define FPD_FN_CMP_LO 6'h30

// ----------------------------------------
// Four-register select values
// ----------------------------------------
`define FPD_OP4_FUSED_MUL_ADD 3'h4
`define FPD_OP4_NEG_MUL_SUBTRACT 3'h7

`endif

// File: pkg/fpd_pkg.sv
// Types shared by the format decoder and its bench.
// Assumes fpd_map.svh supplies the numeric encodings.
package fpd_pkg;

	typedef enum logic [2:0] {
		FPD_F_S,
		FPD_F_D,
		FPD_F_W,
		FPD_F_L,
		FPD_F_PS,
		FPD_F_RSV
	} fpd_fmt_t;

	typedef enum logic [3:0] {
		FPD_C_NONE,
		FPD_C_ARITH,
		FPD_C_SD_ONLY,
		FPD_C_CVT_D,
		FPD_C_CVT_S,
		FPD_C_CVT_PS_PART,
		FPD_C_CVT_FIX,
		FPD_C_MOVE_ON_CC,
		FPD_C_PAIR,
		FPD_C_FOUR_REG,
		FPD_C_MEM,
		FPD_C_BRANCH
	} fpd_class_t;

	typedef struct packed {
		logic valid;
		fpd_class_t op_class;
		logic [5:0] func;
		fpd_fmt_t src_fmt;
		fpd_fmt_t res_fmt;
		logic [4:0] dest_fpr;
		logic [4:0] src_a;
		logic [4:0] src_b;
		logic [4:0] base_reg;
		logic [15:0] offset;
		logic likely;
		logic cond_sense;
		logic rsv_exc;
	} fpd_dec_t;

endpackage

// File: logic/fpd_decoder.sv
// Floating-point instruction field and format decoder.
// Assumes one aligned 32-bit word per valid cycle from the issue stage.
`timescale 1ns/1ns
`default_nettype none
`include "fpd_map.svh"

module fpd_decoder (
	// Clock and reset
	input wire logic i_clk_sys,
	input wire logic i_rst_b,
	input wire logic i_ce,
	// Issue side
	input wire logic i_valid,
	input wire logic [31:0] i_instr,
	// Datapath and exception side
	output fpd_pkg::fpd_dec_t o_dec
);

	// ----------------------------------------
	// Format decode
	// ----------------------------------------
	function automatic fpd_pkg::fpd_fmt_t fmt5(input logic [4:0] c);
		case (c)
			`FPD_FMT_S: fmt5 = fpd_pkg::FPD_F_S;
			`FPD_FMT_D: fmt5 = fpd_pkg::FPD_F_D;
			`FPD_FMT_W: fmt5 = fpd_pkg::FPD_F_W;
			`FPD_FMT_L: fmt5 = fpd_pkg::FPD_F_L;
			`FPD_FMT_PS: fmt5 = fpd_pkg::FPD_F_PS;
			default: fmt5 = fpd_pkg::FPD_F_RSV;
		endcase
	endfunction

	function automatic fpd_pkg::fpd_fmt_t short_operand_format(input logic [2:0] c);
		case (c)
			`FPD_F3_S: short_operand_format = fpd_pkg::FPD_F_S;
			`FPD_F3_D: short_operand_format = fpd_pkg::FPD_F_D;
			`FPD_F3_W: short_operand_format = fpd_pkg::FPD_F_W;
			`FPD_F3_L: short_operand_format = fpd_pkg::FPD_F_L;
			`FPD_F3_PS: short_operand_format = fpd_pkg::FPD_F_PS;
			default: short_operand_format = fpd_pkg::FPD_F_RSV;
		endcase
	endfunction

	function automatic logic is_sd(input fpd_pkg::fpd_fmt_t f);
		is_sd = (f == fpd_pkg::FPD_F_S) || (f == fpd_pkg::FPD_F_D);
	endfunction

	function automatic logic is_sdp(input fpd_pkg::fpd_fmt_t f);
		is_sdp = is_sd(f) || (f == fpd_pkg::FPD_F_PS);
	endfunction

	// ----------------------------------------
	// Field extraction
	// ----------------------------------------
	logic [5:0] opc;
	logic [4:0] fmt_code;
	logic [4:0] reg_t;
	logic [4:0] reg_s;
	logic [4:0] reg_d;
	logic [5:0] func;
	logic [2:0] op4;
	logic [2:0] f3;

	assign opc = i_instr[31:26];
	assign fmt_code = i_instr[25:21];
	assign reg_t = i_instr[20:16];
	assign reg_s = i_instr[15:11];
	assign reg_d = i_instr[10:6];
	assign func = i_instr[5:0];
	assign op4 = i_instr[5:3];
	assign f3 = i_instr[2:0];

	// ----------------------------------------
	// Classification and validity
	// ----------------------------------------
	// Identification looks only at opcode, format and function fields;
	// register and offset fields feed the outputs only.
	fpd_pkg::fpd_dec_t dec_nxt;
	fpd_pkg::fpd_fmt_t sf;
	logic ok;

	always_comb begin
		dec_nxt = '0;
		dec_nxt.valid = i_valid;
		dec_nxt.func = func;
		sf = fmt5(fmt_code);
		ok = 1'b0;
		dec_nxt.op_class = fpd_pkg::FPD_C_NONE;
		dec_nxt.src_a = reg_s;
		dec_nxt.src_b = reg_t;
		dec_nxt.dest_fpr = reg_d;
		case (opc)
			`FPD_OPC_FPU: begin
				if (fmt_code == `FPD_FMT_BC) begin
					dec_nxt.op_class = fpd_pkg::FPD_C_BRANCH;
					dec_nxt.likely = i_instr[17];
					dec_nxt.cond_sense = i_instr[16];
					dec_nxt.offset = i_instr[15:0];
					dec_nxt.dest_fpr = 5'h0_0;
					ok = 1'b1;
				end else if (func == `FPD_FN_ADD || func == `FPD_FN_SUB ||
						func == `FPD_FN_MUL || func == `FPD_FN_ABS ||
						func == `FPD_FN_MOV || func == `FPD_FN_NEG ||
						func >= `FPD_FN_CMP_LO) begin
					dec_nxt.op_class = fpd_pkg::FPD_C_ARITH;
					ok = is_sdp(sf);
					if (func >= `FPD_FN_CMP_LO) begin
						dec_nxt.dest_fpr = 5'h0_0;
					end
				end else if (func == `FPD_FN_DIV || func == `FPD_FN_SQUARE_ROOT ||
						func == `FPD_FN_INV || func == `FPD_FN_INVRT) begin
					dec_nxt.op_class = fpd_pkg::FPD_C_SD_ONLY;
					ok = is_sd(sf);
				end else if (func >= `FPD_FN_MOVCC && func <= `FPD_FN_MOVE_IF_GPR_NONZERO) begin
					dec_nxt.op_class = fpd_pkg::FPD_C_MOVE_ON_CC;
					dec_nxt.cond_sense = i_instr[16];
					ok = is_sdp(sf);
				end else if (func >= `FPD_FN_PAIR_LO && func <= `FPD_FN_PAIR_HI) begin
					dec_nxt.op_class = fpd_pkg::FPD_C_PAIR;
					ok = (sf == fpd_pkg::FPD_F_PS);
				end else if (func == `FPD_FN_CVD) begin
					dec_nxt.op_class = fpd_pkg::FPD_C_CVT_D;
					ok = (sf == fpd_pkg::FPD_F_S) || (sf == fpd_pkg::FPD_F_W) ||
						(sf == fpd_pkg::FPD_F_L);
				end else if (func == `FPD_FN_CVS && sf != fpd_pkg::FPD_F_PS) begin
					dec_nxt.op_class = fpd_pkg::FPD_C_CVT_S;
					ok = (sf == fpd_pkg::FPD_F_D) || (sf == fpd_pkg::FPD_F_W) ||
						(sf == fpd_pkg::FPD_F_L);
				end else if (func == `FPD_FN_CVS || func == `FPD_FN_CVPL) begin
					dec_nxt.op_class = fpd_pkg::FPD_C_CVT_PS_PART;
					ok = (sf == fpd_pkg::FPD_F_PS);
				end else if (func == `FPD_FN_CVW || func == `FPD_FN_CVL ||
						(func >= `FPD_FN_RND_LO && func <= `FPD_FN_RND_HI)) begin
					dec_nxt.op_class = fpd_pkg::FPD_C_CVT_FIX;
					ok = is_sd(sf);
				end
				dec_nxt.src_fmt = sf;
				// Conversions name their result; others keep operand format
				case (dec_nxt.op_class)
					fpd_pkg::FPD_C_CVT_D: dec_nxt.res_fmt = fpd_pkg::FPD_F_D;
					fpd_pkg::FPD_C_CVT_S,
					fpd_pkg::FPD_C_CVT_PS_PART: dec_nxt.res_fmt = fpd_pkg::FPD_F_S;
					fpd_pkg::FPD_C_CVT_FIX: begin
						if (func == `FPD_FN_CVL || func[2] == 1'b0) begin
							dec_nxt.res_fmt = fpd_pkg::FPD_F_L;
						end else begin
							dec_nxt.res_fmt = fpd_pkg::FPD_F_W;
						end
					end
					default: dec_nxt.res_fmt = sf;
				endcase
			end
			`FPD_OPC_FPUX: begin
				sf = short_operand_format(f3);
				dec_nxt.src_fmt = sf;
				dec_nxt.res_fmt = sf;
				dec_nxt.base_reg = fmt_code;
				if (op4 >= `FPD_OP4_FUSED_MUL_ADD && op4 <= `FPD_OP4_NEG_MUL_SUBTRACT) begin
					dec_nxt.op_class = fpd_pkg::FPD_C_FOUR_REG;
					ok = is_sdp(sf);
				end
			end
			`FPD_OPC_LDW, `FPD_OPC_LDD, `FPD_OPC_STW, `FPD_OPC_STD: begin
				dec_nxt.op_class = fpd_pkg::FPD_C_MEM;
				dec_nxt.base_reg = fmt_code;
				dec_nxt.offset = i_instr[15:0];
				dec_nxt.dest_fpr = reg_t;
				dec_nxt.src_a = 5'h0_0;
				dec_nxt.src_b = reg_t;
				ok = 1'b1;
			end
			default: begin
				ok = 1'b0;
			end
		endcase
		// Reserved formats fail is_sd/is_sdp, so they land here as well
		dec_nxt.rsv_exc = i_valid && (dec_nxt.op_class != fpd_pkg::FPD_C_NONE) &&
			!ok;
	end

	// ----------------------------------------
	// Output register
	// ----------------------------------------
	// One word per cycle, no alignment check: fetch guarantees it.
	always_ff @(posedge i_clk_sys or negedge i_rst_b) begin
		if (!i_rst_b) begin
			o_dec <= '0;
		end else if (i_ce) begin
			o_dec <= dec_nxt;
		end
	end

endmodule
`default_nettype wire

// File: tb/fpd_decoder_chk.sv
// Checker for the format decoder: field and exception relations at its ports.
// Assumes one-cycle registered decode of the word taken while i_ce is high.
`timescale 1ns/1ns
`default_nettype none
`include "fpd_map.svh"

module fpd_decoder_chk (
	// Clock and reset
	input wire logic i_clk_sys,
	input wire logic i_rst_b,
	input wire logic i_ce,
	// Issue side
	input wire logic i_valid,
	input wire logic [31:0] i_instr,
	// Decode result
	input wire fpd_pkg::fpd_dec_t o_dec
);
	// ----------------------------------------
	// Helpers
	// ----------------------------------------
	logic [31:0] instr_r;
	logic take;
	logic fpu;
	logic [4:0] fmt;
	assign take = i_ce && i_valid;
	assign fpu = take && (i_instr[31:26] == `FPD_OPC_FPU);
	assign fmt = i_instr[25:21];
	always_ff @(posedge i_clk_sys) begin
		instr_r <= i_instr;
	end
	default clocking cb @(posedge i_clk_sys); endclocking
	default disable iff (!i_rst_b);

	a_idle_no_exc: assert property (i_ce && !i_valid |=> !o_dec.valid && !o_dec.rsv_exc)
		else $error("exception without a word");
	a_reg_fields: assert property (fpu && fmt == `FPD_FMT_D |=> o_dec.func == instr_r[5:0]
		&& o_dec.src_a == instr_r[15:11] && o_dec.src_b == instr_r[20:16]) else $error("reg fields");
	a_mem_fields: assert property (take && i_instr[31:26] == `FPD_OPC_LDD |=>
		o_dec.base_reg == instr_r[25:21] && o_dec.offset == instr_r[15:0]
		&& o_dec.dest_fpr == instr_r[20:16]) else $error("memory fields");
	a_dest_arith: assert property (fpu && fmt == `FPD_FMT_S && i_instr[5:0] == `FPD_FN_ADD
		|=> o_dec.dest_fpr == instr_r[10:6]) else $error("destination field");
	a_fixed_reject: assert property (fpu && fmt inside {`FPD_FMT_W, `FPD_FMT_L}
		&& i_instr[5:0] inside {[0:2], [5:7]} |=> o_dec.rsv_exc) else $error("fixed format taken");
	a_rsv_format: assert property (fpu && fmt inside {5'h12, 5'h13, [5'h17:5'h1f]}
		|=> o_dec.rsv_exc) else $error("reserved format taken");
	a_same_format: assert property (fpu && fmt == `FPD_FMT_D && i_instr[5:0] == `FPD_FN_ADD
		|=> o_dec.valid && o_dec.res_fmt == fpd_pkg::FPD_F_D && !o_dec.rsv_exc) else $error("res fmt");
	a_four_format: assert property (take && i_instr[31:26] == `FPD_OPC_FPUX && i_instr[5]
		|=> o_dec.rsv_exc == !(instr_r[2:0] inside {0, 1, 6})) else $error("four-reg format");
	a_pair_only: assert property (fpu && i_instr[5:0] inside {[6'h2c:6'h2f]}
		|=> o_dec.rsv_exc == (instr_r[25:21] != `FPD_FMT_PS)) else $error("pair merge format");
	a_likely_bit: assert property (fpu && fmt == `FPD_FMT_BC |=> o_dec.likely == instr_r[17]
		&& o_dec.cond_sense == instr_r[16] && !o_dec.rsv_exc) else $error("branch bits");

	a_ce_freeze: assert property (!i_ce |=> $stable(o_dec))
		else $error("output moved with enable low");

	c_exc: cover property (o_dec.rsv_exc);
	c_four: cover property (o_dec.op_class == fpd_pkg::FPD_C_FOUR_REG);
	c_likely: cover property (o_dec.likely);
endmodule

bind fpd_decoder fpd_decoder_chk i_fpd_decoder_chk (.i_clk_sys(i_clk_sys), .i_rst_b(i_rst_b),
	.i_ce(i_ce), .i_valid(i_valid), .i_instr(i_instr), .o_dec(o_dec));
`default_nettype wire

// File: tb/fpd_issue_model.sv
// Issue-stage model: presents one whole aligned word per request.
// Assumes the decoder samples on the rising edge of i_clk_sys.
`timescale 1ns/1ns
`default_nettype none

module fpd_issue_model (
	// Clock
	input wire logic i_clk_sys,
	// Issue side
	output logic o_valid,
	output logic [31:0] o_instr
);
	// ----------------------------------------
	// Issue
	// ----------------------------------------
	initial begin
		o_valid = 1'b0;
		o_instr = 32'h0000_0000;
	end
	// Released word shows its inverse so stale data cannot pass for fresh
	task automatic issue(input logic [31:0] w);
		@(posedge i_clk_sys);
		o_valid <= 1'b1;
		o_instr <= w;
		@(posedge i_clk_sys);
		o_valid <= 1'b0;
		o_instr <= ~w;
	endtask
endmodule
`default_nettype wire

// File: tb/fpd_decoder_tb_top.sv
// Testbench for the format decoder: table-driven format and field checks.
// Assumes the issue model and the bound checker.
`timescale 1ns/1ns
`default_nettype none
`include "fpd_map.svh"

module fpd_decoder_tb_top;
	// ----------------------------------------
	// Hookup
	// ----------------------------------------
	logic i_clk_sys = 1'b0;
	logic i_rst_b = 1'b0;
	logic i_ce = 1'b1;
	logic vld;
	logic [31:0] ins;
	fpd_pkg::fpd_dec_t dec;
	int errors = 0;
	int comparisons = 0;
	logic [4:0] fm [5] = '{`FPD_FMT_S, `FPD_FMT_D, `FPD_FMT_PS, `FPD_FMT_W, `FPD_FMT_L};
	always #25 i_clk_sys = ~i_clk_sys;
	fpd_issue_model i_fpd_issue_model (.i_clk_sys(i_clk_sys), .o_valid(vld), .o_instr(ins));
	fpd_decoder i_fpd_decoder (.i_clk_sys(i_clk_sys), .i_rst_b(i_rst_b), .i_ce(i_ce),
		.i_valid(vld), .i_instr(ins), .o_dec(dec));

	task automatic chk(input logic [15:0] got, input logic [15:0] exp);
		comparisons++;
		if (got !== exp) begin
			errors++;
			$display("[ERR] t=%0t got %h exp %h", $time, got, exp);
		end
	endtask
	task automatic send(input logic [31:0] w);
		i_fpd_issue_model.issue(w);
		#1;
	endtask
	function automatic logic [31:0] rf(input logic [5:0] op, input logic [4:0] f,
		input logic [5:0] fn);
		return {op, f, 5'h09, 5'h0a, 5'h0b, fn};
	endfunction
	// Bit order of the mask: S, D, PS, W, L
	function automatic logic [4:0] ok_mask(input int fn);
		if (fn inside {[0:2], [5:7], [17:19], [48:63]}) return 5'h07;
		if (fn inside {[3:4], [8:15], 21, 22, 36, 37}) return 5'h03;
		if (fn inside {40, [44:47]}) return 5'h04;
		if (fn == 33) return 5'h19;
		if (fn == 32) return 5'h1e;
		return 5'h00;
	endfunction

	// ----------------------------------------
	// Scenarios
	// ----------------------------------------
	task automatic t_fmts;
		for (int f = 0; f < 32; f++) begin
			if (f != 8) begin
				send(rf(`FPD_OPC_FPU, f[4:0], `FPD_FN_ADD));
				chk(16'(dec.rsv_exc), 16'(!(f inside {16, 17, 22})));
			end
		end
		send(rf(`FPD_OPC_FPU, `FPD_FMT_PS, `FPD_FN_MUL));
		chk(16'(dec.res_fmt), 16'(fpd_pkg::FPD_F_PS));
	endtask
	task automatic t_ops;
		logic [4:0] m;
		for (int fn = 0; fn < 64; fn++) begin
			m = ok_mask(fn);
			for (int k = 0; k < 5; k++) begin
				if (m != 5'h00) begin
					send(rf(`FPD_OPC_FPU, fm[k], fn[5:0]));
					chk(16'(dec.rsv_exc), 16'(!m[k]));
				end
			end
		end
	endtask
	task automatic t_conv;
		send(rf(`FPD_OPC_FPU, `FPD_FMT_W, `FPD_FN_CVD));
		chk(16'(dec.res_fmt), 16'(fpd_pkg::FPD_F_D));
		send(rf(`FPD_OPC_FPU, `FPD_FMT_L, `FPD_FN_CVS));
		chk(16'(dec.res_fmt), 16'(fpd_pkg::FPD_F_S));
		send(rf(`FPD_OPC_FPU, `FPD_FMT_S, `FPD_FN_CVW));
		chk(16'(dec.res_fmt), 16'(fpd_pkg::FPD_F_W));
		send(rf(`FPD_OPC_FPU, `FPD_FMT_D, `FPD_FN_CVL));
		chk(16'(dec.res_fmt), 16'(fpd_pkg::FPD_F_L));
		send(rf(`FPD_OPC_FPU, `FPD_FMT_S, 6'h0c));
		chk(16'(dec.res_fmt), 16'(fpd_pkg::FPD_F_W));
	endtask
	task automatic t_four;
		for (int s = 4; s < 8; s++) begin
			for (int f = 0; f < 8; f++) begin
				send({`FPD_OPC_FPUX, 5'h01, 5'h02, 5'h03, 5'h04, s[2:0], f[2:0]});
				chk(16'(dec.rsv_exc), 16'(!(f inside {0, 1, 6})));
			end
		end
	endtask
	task automatic t_fields;
		send({`FPD_OPC_LDD, 5'h15, 5'h0e, 16'ha5c3});
		chk(16'(dec.base_reg), 16'h0015);
		chk(dec.offset, 16'ha5c3);
		chk(16'(dec.dest_fpr), 16'h000e);
		send(rf(`FPD_OPC_FPU, `FPD_FMT_D, `FPD_FN_ADD));
		chk({dec.src_a, dec.src_b, dec.dest_fpr, 1'b0}, {5'h0a, 5'h09, 5'h0b, 1'b0});
		send({`FPD_OPC_FPU, `FPD_FMT_D, 15'h7fff, `FPD_FN_ADD});
		chk(16'(dec.op_class), 16'(fpd_pkg::FPD_C_ARITH));
	endtask
	task automatic t_branch;
		send({`FPD_OPC_FPU, `FPD_FMT_BC, 3'h0, 2'h2, 16'h0040});
		chk(16'({dec.likely, dec.cond_sense, dec.rsv_exc}), 16'h0004);
		send({`FPD_OPC_FPU, `FPD_FMT_BC, 3'h0, 2'h1, 16'h0040});
		chk(16'({dec.likely, dec.cond_sense, dec.rsv_exc}), 16'h0002);
	endtask
	// Clock enable low must freeze the output; a mid-run reset must clear it
	task automatic t_ce_rst;
		@(posedge i_clk_sys);
		i_ce <= 1'b0;
		send(rf(`FPD_OPC_FPU, `FPD_FMT_W, `FPD_FN_ADD));
		chk(16'({dec.valid, dec.rsv_exc}), 16'h0000);
		@(posedge i_clk_sys);
		i_ce <= 1'b1;
		send(rf(`FPD_OPC_FPU, `FPD_FMT_D, `FPD_FN_SUB));
		chk(16'({dec.valid, dec.rsv_exc}), 16'h0002);
		chk(16'(dec.src_fmt), 16'(fpd_pkg::FPD_F_D));
		@(posedge i_clk_sys);
		i_rst_b <= 1'b0;
		#1;
		chk(16'({dec.valid, dec.op_class}), 16'h0000);
		@(posedge i_clk_sys);
		i_rst_b <= 1'b1;
		send(rf(`FPD_OPC_FPU, `FPD_FMT_PS, `FPD_FN_DIV));
		chk(16'({dec.valid, dec.rsv_exc}), 16'h0003);
	endtask
	task automatic end_sim;
		if (errors == 0 && comparisons > 0) begin
			$display("SIMULATION PASSED");
		end else begin
			$display("SIMULATION FAILED");
		end
		$finish;
	endtask

	initial begin
		repeat (5) @(posedge i_clk_sys);
		i_rst_b <= 1'b1;
		t_fmts;
		t_ops;
		t_conv;
		t_four;
		t_fields;
		t_branch;
		t_ce_rst;
		end_sim;
	end
	// About 620 cycles are needed; 20000 leaves ample margin
	initial begin
		#1000000;
		errors++;
		end_sim;
	end
endmodule
`default_nettype wire
